// ==== core/odl_defs.svh ====
// Purpose: constants for the opcode decode logic
// Assumes: opcode bytes arrive from the prefetch queue, one per cycle when valid
// Notes: Operation list follows
// Operation
// - byte F0 locks bus for next instruction
// - 001 sr 110 overrides next segment
// - 11011xxx plus modrm is coprocessor handoff
// - F6/F7 reg selects test, not, negate, multiply
// - F6/F7 reg 110/111 divide, with displacement
// - D4/D5 need second byte 0A
// - D0-D3 reg selects rotate or shift kind
// - bits 5..3 pick alu op, d, w
// - test updates flags only; A8/A9 immediate
// - E9 word, EB byte, EA far, FF indirect
// - C3/CB return, C2/CA add immediate to stack
// - 7x short branch, condition code, one offset
// - loop family E0-E3 with byte offset
// - CD type byte, CC type 3, CE, CF
// - F8 F9 F5 carry, FC FD direction
// - FA FB interrupt flag, F4 stop, 9B wait
// - 98 byte sign extend, 99 word
// - 3F and 2F subtract decimal fixups
// - segment code 00 ES 01 CS 10 SS 11 DS
// - s and w set sign-extends one byte
// - mod selects zero, one, two displacement
`ifndef ODL_DEFS_SVH
`define ODL_DEFS_SVH
`define ODL_LOCK_PFX 8'hF0
`define ODL_BCD_SECOND 8'h0A
`define ODL_INT3_TYPE 4'h3
`define ODL_SEG_DS 2'h3
`endif

// ==== core/odl_pkg.sv ====
// Purpose: types for the opcode decode logic
// Assumes: nothing beyond the defs header
// Notes: op_e codes one operation class per value
package odl_pkg;
    typedef enum logic [5:0] {
        OP_NONE, OP_ALU, OP_TEST, OP_NOT, OP_NEG, OP_MULU, OP_MULS, OP_DIVU, OP_DIVS,
        OP_BCD_MUL, OP_BCD_DIV, OP_SHIFT, OP_JMP, OP_CALL, OP_RET, OP_JCC, OP_LOOP,
        OP_INT, OP_INTO, OP_TRAP_RETURN, OP_FLAG, OP_HALT, OP_WAIT, OP_SEXT_B, OP_SEXT_W,
        OP_ASCII_SUB, OP_DEC_SUB, OP_ESC, OP_STRING, OP_OTHER, OP_UNDEF
    } odl_op_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_MODRM = 4'b0010,
        ST_TAIL = 4'b0100,
        ST_DONE = 4'b1000
    } odl_state_e;
    typedef struct packed {
        odl_op_e op;
        logic [2:0] sub;
        logic [3:0] cond;
        logic wide;
        logic dir;
        logic count_reg;
        logic sign_ext;
        logic lock;
        logic seg_ovr;
        logic [1:0] seg;
        logic string_repeat_prefix;
        logic rep_z;
        logic [2:0] n_disp;
        logic [2:0] n_imm;
        logic undef;
    } odl_dec_s;
    typedef struct packed {
        odl_state_e st;
        odl_dec_s dec;
        logic [7:0] op_byte;
        logic [2:0] left;
        logic pf_lock;
        logic pf_seg;
        logic [1:0] pf_sreg;
        logic pf_rep;
        logic pf_repz;
        logic dec_valid;
    } odl_state_s;
endpackage : odl_pkg

// ==== core/odl_decoder.sv ====
// Purpose: classify opcode bytes into an operation and its byte counts
// Assumes: byte_valid marks one queue byte per cycle; decode consumes every byte
// Notes: trailing disp/imm bytes are counted and skipped, not captured
`timescale 1ns/1ps
`include "odl_defs.svh"
module odl_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    output logic byte_ready,
    output logic dec_valid,
    output odl_pkg::odl_dec_s dec
);
    odl_pkg::odl_state_s s_r;
    odl_pkg::odl_state_s s_nxt;

    function automatic logic [2:0] disp_len(input logic [7:0] m);
        if (m[7:6] == 2'b01) begin
            disp_len = 3'd1;
        end else if (m[7:6] == 2'b10 || (m[7:6] == 2'b00 && m[2:0] == 3'b110)) begin
            disp_len = 3'd2;
        end else begin
            disp_len = 3'd0;
        end
    endfunction : disp_len

    function automatic odl_pkg::odl_dec_s first(input logic [7:0] b);
        odl_pkg::odl_dec_s d;
        d = '0;
        d.op = odl_pkg::OP_OTHER;
        d.wide = b[0];
        d.seg = `ODL_SEG_DS;
        if (b[7:6] == 2'b00 && b[2] == 1'b0) begin
            d.op = odl_pkg::OP_ALU;
            d.sub = b[5:3];
            d.dir = b[1];
        end else if (b[7:6] == 2'b00 && b[2:1] == 2'b10) begin
            d.op = odl_pkg::OP_ALU;
            d.sub = b[5:3];
            d.n_imm = b[0] ? 3'd2 : 3'd1;
        end
        casez (b)
            8'b001?_?110: d.op = odl_pkg::OP_OTHER;
            8'h3F: d.op = odl_pkg::OP_ASCII_SUB;
            8'h2F: d.op = odl_pkg::OP_DEC_SUB;
            8'h0F, 8'b0110_????: d.undef = 1'b1;
            8'b0111_????: begin
                d.op = odl_pkg::OP_JCC;
                d.cond = b[3:0];
                d.n_imm = 3'd1;
            end
            8'b1000_01?0, 8'b1000_01?1: begin
                if (b[1] == 1'b0) begin
                    d.op = odl_pkg::OP_TEST;
                end
            end
            8'b1010_100?: begin
                d.op = odl_pkg::OP_TEST;
                d.n_imm = b[0] ? 3'd2 : 3'd1;
            end
            8'b1010_01??, 8'b1010_101?, 8'b1010_11??: begin
                d.op = odl_pkg::OP_STRING;
                d.sub = b[3:1];
            end
            8'b1000_00??: begin
                d.op = odl_pkg::OP_ALU;
                d.sign_ext = b[1] & b[0];
                d.n_imm = (b[0] & ~b[1]) ? 3'd2 : 3'd1;
            end
            8'h98: d.op = odl_pkg::OP_SEXT_B;
            8'h99: d.op = odl_pkg::OP_SEXT_W;
            8'h9A: begin
                d.op = odl_pkg::OP_CALL;
                d.n_imm = 3'd4;
            end
            8'h9B: d.op = odl_pkg::OP_WAIT;
            8'hC3, 8'hCB: d.op = odl_pkg::OP_RET;
            8'hC2, 8'hCA: begin
                d.op = odl_pkg::OP_RET;
                d.n_imm = 3'd2;
            end
            8'hCC: begin
                d.op = odl_pkg::OP_INT;
                d.cond = `ODL_INT3_TYPE;
            end
            8'hCD: begin
                d.op = odl_pkg::OP_INT;
                d.n_imm = 3'd1;
            end
            8'hCE: d.op = odl_pkg::OP_INTO;
            8'hCF: d.op = odl_pkg::OP_TRAP_RETURN;
            8'b1101_00??: begin
                d.op = odl_pkg::OP_SHIFT;
                d.count_reg = b[1];
            end
            8'hD4: d.op = odl_pkg::OP_BCD_MUL;
            8'hD5: d.op = odl_pkg::OP_BCD_DIV;
            8'b1101_1???: begin
                d.op = odl_pkg::OP_ESC;
                d.sub = b[2:0];
            end
            8'b1110_00??: begin
                d.op = (b[1:0] == 2'b11) ? odl_pkg::OP_JCC : odl_pkg::OP_LOOP;
                d.cond = {2'b00, b[1:0]};
                d.n_imm = 3'd1;
            end
            8'hE8, 8'hE9: begin
                d.op = b[0] ? odl_pkg::OP_JMP : odl_pkg::OP_CALL;
                d.n_imm = 3'd2;
            end
            8'hEA: begin
                d.op = odl_pkg::OP_JMP;
                d.n_imm = 3'd4;
            end
            8'hEB: begin
                d.op = odl_pkg::OP_JMP;
                d.n_imm = 3'd1;
            end
            8'hF4: d.op = odl_pkg::OP_HALT;
            8'hF5, 8'b1111_100?, 8'b1111_110?, 8'b1111_101?: begin
                d.op = odl_pkg::OP_FLAG;
                d.sub = b[2:0];
            end
            8'b1111_011?: d.op = odl_pkg::OP_TEST;
            8'hFF, 8'hFE: d.op = odl_pkg::OP_OTHER;
            default: begin
            end
        endcase
        first = d;
    endfunction : first

    function automatic logic needs_modrm(input logic [7:0] b);
        casez (b)
            8'b00??_?0??, 8'b1000_????, 8'b1100_01??, 8'b1100_011?: needs_modrm = ~b[7] | 1'b1;
            8'b1101_????, 8'b1111_011?, 8'b1111_111?: needs_modrm = 1'b1;
            default: needs_modrm = 1'b0;
        endcase
        if (b[7:6] == 2'b00 && b[2] == 1'b1) begin
            needs_modrm = 1'b0;
        end
        if (b[7:4] == 4'h8 && b[3:1] == 3'b100 && b[0] == 1'b1) begin
            needs_modrm = 1'b1;
        end
    endfunction : needs_modrm

    always_comb begin
        s_nxt = s_r;
        s_nxt.dec_valid = 1'b0;
        case (s_r.st)
            odl_pkg::ST_IDLE, odl_pkg::ST_DONE: begin
                s_nxt.st = odl_pkg::ST_IDLE;
                if (s_r.st == odl_pkg::ST_DONE) begin
                    s_nxt.dec_valid = 1'b1;
                end
                // a byte offered in the done cycle is refused, the queue holds it
                if (byte_valid && s_r.st == odl_pkg::ST_IDLE) begin
                    casez (byte_in)
                        `ODL_LOCK_PFX: s_nxt.pf_lock = 1'b1;
                        8'b001?_?110: begin
                            s_nxt.pf_seg = 1'b1;
                            s_nxt.pf_sreg = byte_in[4:3];
                        end
                        8'b1111_001?: begin
                            s_nxt.pf_rep = 1'b1;
                            s_nxt.pf_repz = byte_in[0];
                        end
                        default: begin
                            s_nxt.op_byte = byte_in;
                            s_nxt.dec = first(byte_in);
                            s_nxt.dec.lock = s_r.pf_lock;
                            s_nxt.dec.seg_ovr = s_r.pf_seg;
                            s_nxt.dec.seg = s_r.pf_seg ? s_r.pf_sreg : `ODL_SEG_DS;
                            s_nxt.dec.string_repeat_prefix = s_r.pf_rep;
                            s_nxt.dec.rep_z = s_r.pf_repz;
                            s_nxt.pf_lock = 1'b0;
                            s_nxt.pf_seg = 1'b0;
                            s_nxt.pf_rep = 1'b0;
                            s_nxt.left = s_nxt.dec.n_imm;
                            if (needs_modrm(byte_in) || byte_in == 8'hD4 || byte_in == 8'hD5) begin
                                s_nxt.st = odl_pkg::ST_MODRM;
                            end else if (s_nxt.dec.n_imm != 3'd0) begin
                                s_nxt.st = odl_pkg::ST_TAIL;
                            end else begin
                                s_nxt.st = odl_pkg::ST_DONE;
                            end
                        end
                    endcase
                end
            end
            odl_pkg::ST_MODRM: begin
                if (byte_valid) begin
                    s_nxt.st = odl_pkg::ST_TAIL;
                    s_nxt.dec.n_disp = disp_len(byte_in);
                    casez (s_r.op_byte)
                        8'b1111_011?: begin
                            case (byte_in[5:3])
                                3'b000: s_nxt.dec.op = odl_pkg::OP_TEST;
                                3'b010: s_nxt.dec.op = odl_pkg::OP_NOT;
                                3'b011: s_nxt.dec.op = odl_pkg::OP_NEG;
                                3'b100: s_nxt.dec.op = odl_pkg::OP_MULU;
                                3'b101: s_nxt.dec.op = odl_pkg::OP_MULS;
                                3'b110: s_nxt.dec.op = odl_pkg::OP_DIVU;
                                3'b111: s_nxt.dec.op = odl_pkg::OP_DIVS;
                                default: s_nxt.dec.undef = 1'b1;
                            endcase
                            s_nxt.left = 3'd0;
                            if (byte_in[5:3] == 3'b000) begin
                                s_nxt.left = s_r.op_byte[0] ? 3'd2 : 3'd1;
                            end
                            s_nxt.dec.n_imm = s_nxt.left;
                        end
                        8'b1101_00??: begin
                            s_nxt.dec.sub = byte_in[5:3];
                            s_nxt.dec.undef = (byte_in[5:3] == 3'b110);
                        end
                        8'hD4, 8'hD5: begin
                            s_nxt.dec.n_disp = 3'd0;
                            s_nxt.dec.undef = (byte_in != `ODL_BCD_SECOND);
                        end
                        8'b1101_1???: s_nxt.dec.sub = byte_in[5:3];
                        8'b1000_00??: s_nxt.dec.sub = byte_in[5:3];
                        8'hFF: begin
                            case (byte_in[5:3])
                                3'b010, 3'b011: s_nxt.dec.op = odl_pkg::OP_CALL;
                                3'b100, 3'b101: s_nxt.dec.op = odl_pkg::OP_JMP;
                                3'b111: s_nxt.dec.undef = 1'b1;
                                default: s_nxt.dec.op = odl_pkg::OP_OTHER;
                            endcase
                        end
                        default: begin
                        end
                    endcase
                    s_nxt.left = s_nxt.left + s_nxt.dec.n_disp;
                    if (s_nxt.left == 3'd0) begin
                        s_nxt.st = odl_pkg::ST_DONE;
                    end
                end
            end
            odl_pkg::ST_TAIL: begin
                if (s_r.left <= 3'd1) begin
                    s_nxt.st = byte_valid ? odl_pkg::ST_DONE : s_r.st;
                end
                if (byte_valid) begin
                    s_nxt.left = s_r.left - 3'd1;
                end
            end
            default: s_nxt.st = odl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= odl_pkg::odl_state_s'({odl_pkg::ST_IDLE,
                {($bits(odl_pkg::odl_state_s) - 4){1'b0}}});
        end else begin
            s_r <= s_nxt;
        end
    end

    assign byte_ready = (s_r.st != odl_pkg::ST_DONE);
    assign dec_valid = s_r.dec_valid;
    assign dec = s_r.dec;

    a_int3_type: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == odl_pkg::ST_IDLE && byte_valid && byte_in == 8'hCC)
        |-> ##2 (dec_valid && dec.op == odl_pkg::OP_INT && dec.cond == 4'h3))
        else $error("type 3 interrupt misdecoded");
    a_lock_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == odl_pkg::ST_IDLE && byte_valid && byte_in == 8'hF0)
        |=> s_r.pf_lock)
        else $error("lock prefix not held");
    a_shift_count: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec.op == odl_pkg::OP_SHIFT |-> dec.count_reg == s_r.op_byte[1])
        else $error("shift count source wrong");
    a_jcc_offset: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec.op == odl_pkg::OP_JCC |-> dec.n_imm == 3'd1)
        else $error("short branch offset count wrong");
    a_sext_byte: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec.sign_ext |-> dec.n_imm == 3'd1)
        else $error("sign extended immediate count wrong");
    a_undef_0f: assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.st == odl_pkg::ST_IDLE && byte_valid && byte_in == 8'h0F) |-> ##2 dec.undef)
        else $error("unused opcode not flagged");
    a_ret_imm: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec.op == odl_pkg::OP_RET |-> dec.n_imm == {s_r.op_byte[0] ? 3'd0 : 3'd2})
        else $error("return immediate count wrong");
    a_seg_default: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && !dec.seg_ovr |-> dec.seg == 2'h3)
        else $error("default segment not data");
endmodule : odl_decoder

// ==== verification/odl_queue_model.sv ====
// Purpose: prefetch queue model offering opcode bytes to the decoder
// Assumes: a byte is held until taken at an edge with byte_ready high
// Notes: idle byte lines toggle so a stale byte is never mistaken for a fresh one
`timescale 1ns/1ps
module odl_queue_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic byte_ready,
    output logic byte_valid,
    output logic [7:0] byte_in
);
    logic [11:0] fifo[$];

    initial begin
        byte_valid = 1'b0;
        byte_in = 8'h00;
    end

    // upper nibble delays the head byte, so the queue can run dry between bytes
    task automatic push(input logic [7:0] b, input logic [3:0] gap);
        fifo.push_back({gap, b});
    endtask : push

    always @(posedge clk) begin : feed
        logic nv;
        logic [7:0] nd;
        nv = byte_valid && !byte_ready;
        nd = nv ? byte_in : ~byte_in;
        if (byte_valid && byte_ready) begin
            void'(fifo.pop_front());
        end
        if (!nv && rst_n && fifo.size() > 0) begin
            if (fifo[0][11:8] == 4'h0) begin
                nv = 1'b1;
                nd = fifo[0][7:0];
            end else begin
                fifo[0][11:8] = fifo[0][11:8] - 4'h1;
            end
        end
        byte_valid <= nv && rst_n;
        byte_in <= nd;
    end
endmodule : odl_queue_model

// ==== verification/odl_decoder_tb.sv ====
// Purpose: self-checking bench for the opcode decoder
// Assumes: one result pulse per instruction, prefixes fold into the next one
// Notes: offsets and data bytes are checked as a total; displacement count is also checked alone when an addressing byte is sent
`timescale 1ns/1ps
module odl_decoder_tb;
    typedef struct {
        odl_pkg::odl_op_e op;
        logic [2:0] nd;
        logic [2:0] nt;
        logic [2:0] xk;
        logic [3:0] xv;
        logic [3:0] fl;
    } odl_exp_s;

    logic clk = 1'b0;
    logic rst_n;
    logic byte_valid;
    logic [7:0] byte_in;
    logic byte_ready;
    logic dec_valid;
    odl_pkg::odl_dec_s dec;
    odl_exp_s notes[$];
    integer seed = 62;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] flg[7] = '{8'hF8, 8'hF9, 8'hF5, 8'hFC, 8'hFD, 8'hFA, 8'hFB};
    logic [7:0] one[10] = '{8'hF4, 8'h9B, 8'h98, 8'h99, 8'h3F, 8'h2F, 8'hCE, 8'hCF, 8'hC3, 8'hCB};
    odl_pkg::odl_op_e one_op[10] = '{odl_pkg::OP_HALT, odl_pkg::OP_WAIT, odl_pkg::OP_SEXT_B,
        odl_pkg::OP_SEXT_W, odl_pkg::OP_ASCII_SUB, odl_pkg::OP_DEC_SUB, odl_pkg::OP_INTO,
        odl_pkg::OP_TRAP_RETURN, odl_pkg::OP_RET, odl_pkg::OP_RET};
    odl_pkg::odl_op_e grp[8] = '{odl_pkg::OP_TEST, odl_pkg::OP_UNDEF, odl_pkg::OP_NOT,
        odl_pkg::OP_NEG, odl_pkg::OP_MULU, odl_pkg::OP_MULS, odl_pkg::OP_DIVU, odl_pkg::OP_DIVS};

    always #5 clk = ~clk;

    odl_decoder odl_decoder_i (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
        .byte_in(byte_in), .byte_ready(byte_ready), .dec_valid(dec_valid), .dec(dec));
    odl_queue_model odl_queue_model_i (.clk(clk), .rst_n(rst_n), .byte_ready(byte_ready),
        .byte_valid(byte_valid), .byte_in(byte_in));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // fl is {undefined, lock, segment override, repeat}
    function automatic odl_exp_s mk(input odl_pkg::odl_op_e op, input logic [2:0] xk = 3'h0,
                                    input logic [3:0] xv = 4'h0, input logic [3:0] fl = 4'h0);
        return '{op, 3'h0, 3'h0, xk, xv, fl};
    endfunction : mk

    task automatic put(input logic [7:0] b);
        odl_queue_model_i.push(b, (($random(seed) & 7) == 0) ? 4'h2 : 4'h0);
    endtask : put

    // opcode, optional addressing byte with random form, then random trailing bytes
    task automatic issue(input logic [7:0] opc, input logic am, input logic [2:0] r,
                         input logic [2:0] ni, input odl_exp_s e);
        logic [7:0] m;
        m = 8'($random(seed));
        m[5:3] = r;
        put(opc);
        e.nd = 3'h7;
        if (am) begin
            e.nd = (m[7:6] == 2'h1) ? 3'h1
                : (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) ? 3'h2 : 3'h0;
            put(m);
        end
        e.nt = ni + (am ? e.nd : 3'h0);
        repeat (e.nt) put(8'($random(seed)));
        notes.push_back(e);
    endtask : issue

    always @(posedge clk) begin : watch
        odl_exp_s e;
        if (rst_n && dec_valid === 1'b1) begin
            if (notes.size() == 0) begin
                check({7'h0, dec_valid}, 8'h00);
            end else begin
                e = notes.pop_front();
                if (!e.fl[3]) check(8'(dec.op), 8'(e.op));
                if (e.nd != 3'h7) check(8'(dec.n_disp), 8'(e.nd));
                check(8'(dec.n_disp) + 8'(dec.n_imm), 8'(e.nt));
                check({4'h0, dec.undef, dec.lock, dec.seg_ovr, dec.string_repeat_prefix}, {4'h0, e.fl});
                case (e.xk)
                    3'h1: check({4'h0, dec.cond}, {4'h0, e.xv});
                    3'h2: check({5'h0, dec.sub}, {4'h0, e.xv});
                    3'h3: check({6'h0, dec.seg}, {4'h0, e.xv});
                    3'h4: check({7'h0, dec.count_reg}, {4'h0, e.xv});
                    3'h5: check({7'h0, dec.sign_ext}, {4'h0, e.xv});
                    3'h6: check({7'h0, dec.rep_z}, {4'h0, e.xv});
                    3'h7: check({6'h0, dec.dir, dec.wide}, {4'h0, e.xv});
                    default: ;
                endcase
            end
        end
    end

    // a hang shows as results that never arrive
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'b0;
        for (int i = 0; i < 16; i++) issue(8'h70 | 8'(i), 0, 0, 1, mk(odl_pkg::OP_JCC, 1, 4'(i)));
        for (int i = 0; i < 3; i++) issue(8'hE0 | 8'(i), 0, 0, 1, mk(odl_pkg::OP_LOOP, 1, 4'(i)));
        issue(8'hE3, 0, 0, 1, mk(odl_pkg::OP_JCC, 1, 4'h3));
        issue(8'hCC, 0, 0, 0, mk(odl_pkg::OP_INT, 1, 4'h3));
        issue(8'hCD, 0, 0, 1, mk(odl_pkg::OP_INT));
        foreach (flg[i]) issue(flg[i], 0, 0, 0, mk(odl_pkg::OP_FLAG, 2, 4'(flg[i][2:0])));
        foreach (one[i]) issue(one[i], 0, 0, 0, mk(one_op[i]));
        for (int k = 0; k < 16; k++) begin
            if (k[2:0] != 3'h1) issue(8'hF6 | 8'(k[3]), 1, 3'(k), (k[2:0] == 3'h0) ? 3'(k[3] + 1) : 3'h0,
                mk(grp[k[2:0]]));
            issue(8'hD0 | 8'(k[3:2]), 1, 3'(k), 0, (k[1:0] == 2'h2 && k[2]) ? mk(odl_pkg::OP_UNDEF, 0, 0, 8)
                : k[0] ? mk(odl_pkg::OP_SHIFT, 4, 4'(k[3])) : mk(odl_pkg::OP_SHIFT, 2, 4'(k[2:0])));
        end
        put(8'hD4);
        issue(8'h0A, 0, 0, 0, mk(odl_pkg::OP_BCD_MUL));
        put(8'hD5);
        issue(8'h0A, 0, 0, 0, mk(odl_pkg::OP_BCD_DIV));
        put(8'hD4);
        issue(8'h0B, 0, 0, 0, mk(odl_pkg::OP_UNDEF, 0, 0, 8));
        for (int k = 0; k < 48; k++) issue(8'((k / 6) * 8 + k % 6), k % 6 < 4, 3'(k), (k % 6 < 4) ? 3'h0
            : 3'(k % 6 - 3), mk(odl_pkg::OP_ALU, (k % 6 == 0 || k % 6 > 3) ? 3'h2 : 3'h7,
            (k % 6 == 0 || k % 6 > 3) ? 4'(k / 6) : 4'(k % 6)));
        for (int r = 0; r < 8; r++) begin
            issue(8'h80, 1, 3'(r), 1, mk(odl_pkg::OP_ALU, 2, 4'(r)));
            issue(8'h81, 1, 3'(r), 2, mk(odl_pkg::OP_ALU, 5, 4'h0));
            issue(8'hD8 | 8'(r), 1, 3'(r), 0, mk(odl_pkg::OP_ESC));
        end
        issue(8'h83, 1, 3'h7, 1, mk(odl_pkg::OP_ALU, 5, 4'h1));
        issue(8'hA8, 0, 0, 1, mk(odl_pkg::OP_TEST));
        issue(8'hA9, 0, 0, 2, mk(odl_pkg::OP_TEST));
        issue(8'hE9, 0, 0, 2, mk(odl_pkg::OP_JMP));
        issue(8'hEB, 0, 0, 1, mk(odl_pkg::OP_JMP));
        issue(8'hEA, 0, 0, 4, mk(odl_pkg::OP_JMP));
        issue(8'hE8, 0, 0, 2, mk(odl_pkg::OP_CALL));
        issue(8'h9A, 0, 0, 4, mk(odl_pkg::OP_CALL));
        issue(8'h84, 1, 3'h2, 0, mk(odl_pkg::OP_TEST));
        issue(8'h85, 1, 3'h5, 0, mk(odl_pkg::OP_TEST));
        for (int r = 2; r < 6; r++) issue(8'hFF, 1, 3'(r), 0,
            mk(r < 4 ? odl_pkg::OP_CALL : odl_pkg::OP_JMP));
        issue(8'hC2, 0, 0, 2, mk(odl_pkg::OP_RET));
        issue(8'hCA, 0, 0, 2, mk(odl_pkg::OP_RET));
        put(8'hF0);
        issue(8'hF8, 0, 0, 0, mk(odl_pkg::OP_FLAG, 2, 4'h0, 4));
        issue(8'hF9, 0, 0, 0, mk(odl_pkg::OP_FLAG, 2, 4'h1));
        for (int s = 0; s < 4; s++) begin
            put(8'h26 | 8'(s << 3));
            issue(8'h00, 1, 3'(s), 0, mk(odl_pkg::OP_ALU, 3, 4'(s), 2));
        end
        issue(8'h00, 1, 3'h1, 0, mk(odl_pkg::OP_ALU, 2, 4'h0));
        for (int k = 4; k < 16; k++) begin
            if (k != 8 && k != 9) begin
                put(8'hF2 | 8'(k[1]));
                issue(8'hA0 | 8'(k), 0, 0, 0, mk(odl_pkg::OP_STRING, 6, 4'(k[1]), 1));
            end
        end
        issue(8'hA4, 0, 0, 0, mk(odl_pkg::OP_STRING));
        issue(8'h0F, 0, 0, 0, mk(odl_pkg::OP_UNDEF, 0, 0, 8));
        issue(8'h6A, 0, 0, 0, mk(odl_pkg::OP_UNDEF, 0, 0, 8));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 19000 && notes.size() > 0; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        // results still owed mean the decoder stalled
        if (notes.size() > 0) begin
            mismatches++;
        end
        complete_run();
    end
endmodule : odl_decoder_tb
